// [logic/pdca_pkg.sv]
// Package with register offsets, field layout and reset values of the pin clear alias block.
package pdca_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_FUNC_SEL = 8'h10;
  localparam logic [7:0] OFF_DIRECTION = 8'h14;
  localparam logic [7:0] OFF_OUT_LATCH = 8'h18;
  localparam logic [7:0] OFF_CLEAR_MASK = 8'h20;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int unsigned MUTE_BIT = 25;
  localparam int unsigned RX_FS_BIT = 31;
  localparam int unsigned DATA_TOP_BIT = 15;
  localparam int unsigned RSVD_LO_BIT = 16;
  localparam int unsigned RSVD_HI_BIT = 24;
  localparam logic [31:0] IMPL_MASK = 32'hfe00ffff;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] RST_LATCH = 32'h00000000;
  localparam logic [31:0] RST_FUNC = 32'h00000000;
  localparam logic [31:0] RST_DIR = 32'h00000000;
  localparam logic [31:0] RST_RDATA = 32'h00000000;

endpackage : pdca_pkg

// [logic/pdca_pin_if.sv]
// Interface that carries latch and pin control from the register file to the pin driver.
`timescale 1ns/10ps
interface pdca_pin_if;
  logic [31:0] latch;
  logic [31:0] func_sel;
  logic [31:0] direction;
  logic [31:0] pin_out;
  logic [31:0] pin_oe;

  modport regs (
    output latch,
    output func_sel,
    output direction,
    input pin_out,
    input pin_oe
  );

  modport drv (
    input latch,
    input func_sel,
    input direction,
    output pin_out,
    output pin_oe
  );
endinterface : pdca_pin_if

// [logic/pdca_pin_drv.sv]
// Pin driver that turns latch, function select and direction into registered pin levels.
`timescale 1ns/10ps
module pdca_pin_drv (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  pdca_pin_if.drv pins
);

  logic [31:0] gpio_out;

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // A pin is driven only when it is a general-purpose output.
  assign gpio_out = pins.func_sel & pins.direction & pdca_pkg::IMPL_MASK;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pins.pin_out <= pdca_pkg::RST_LATCH;
      pins.pin_oe <= pdca_pkg::RST_DIR;
    end else begin
      pins.pin_out <= pins.latch & gpio_out; // R03
      pins.pin_oe <= gpio_out; // R03
    end
  end

endmodule : pdca_pin_drv

// [logic/pdca_top.sv]
// Register file with the write-only clear alias of the pin output latch, on APB.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps

// Function
// R01 - Clear alias is write-only, without storage.
// R02 - Written ones clear latch; zeros keep it.
// R03 - Cleared general-purpose output pins drive low.
// R04 - Unselected pins keep their output state.
// R05 - Bits 31 to 25 clear control pins.
// R06 - Bits 15 to 0 clear data pins.
// R07 - Reserved bits 24 to 16 read zero.
// R08 - Software writes zero to reserved bits.
// R09 - Clear lands in the accepting bus cycle.
module pdca_top (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] pin_out_o,
  output logic [31:0] pin_oe_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clears the masked, implemented bits of a latch value.
  function automatic logic [31:0] clear_bits(input logic [31:0] value, input logic [31:0] mask);
    clear_bits = value & ~(mask & pdca_pkg::IMPL_MASK);
  endfunction : clear_bits

  // Tells whether an address belongs to a mapped register.
  function automatic logic addr_mapped(input logic [7:0] addr);
    if (addr == pdca_pkg::OFF_FUNC_SEL) begin
      addr_mapped = 1'b1;
    end else if (addr == pdca_pkg::OFF_DIRECTION) begin
      addr_mapped = 1'b1;
    end else if (addr == pdca_pkg::OFF_OUT_LATCH) begin
      addr_mapped = 1'b1;
    end else if (addr == pdca_pkg::OFF_CLEAR_MASK) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  endfunction : addr_mapped

  pdca_pin_if pins ();

  logic [31:0] latch_q;
  logic [31:0] latch_d;
  logic [31:0] func_q;
  logic [31:0] dir_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_en;
  logic setup;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  assign setup = psel_i & ~penable_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_mapped(paddr_i);
  assign wr_en = psel_i & penable_i & pwrite_i & addr_mapped(paddr_i);
  assign prdata_o = rdata_q;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdata_d = pdca_pkg::RST_RDATA;
    if (paddr_i == pdca_pkg::OFF_FUNC_SEL) begin
      rdata_d = func_q;
    end else if (paddr_i == pdca_pkg::OFF_DIRECTION) begin
      rdata_d = dir_q;
    end else if (paddr_i == pdca_pkg::OFF_OUT_LATCH) begin
      rdata_d = latch_q & pdca_pkg::IMPL_MASK; // R07
    end else begin
      rdata_d = pdca_pkg::RST_RDATA; // R01
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= pdca_pkg::RST_RDATA;
    end else if (setup & ~pwrite_i) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Output latch
  // ----------------------------------------
  always_comb begin
    latch_d = latch_q;
    if (wr_en & (paddr_i == pdca_pkg::OFF_OUT_LATCH)) begin
      latch_d = pwdata_i & pdca_pkg::IMPL_MASK; // R07
    end else if (wr_en & (paddr_i == pdca_pkg::OFF_CLEAR_MASK)) begin
      latch_d = clear_bits(latch_q, pwdata_i); // R02 R04 R05 R06
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      latch_q <= pdca_pkg::RST_LATCH;
    end else begin
      latch_q <= latch_d; // R01 R09
    end
  end

  // ----------------------------------------
  // Function select and direction
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      func_q <= pdca_pkg::RST_FUNC;
    end else if (wr_en & (paddr_i == pdca_pkg::OFF_FUNC_SEL)) begin
      func_q <= pwdata_i & pdca_pkg::IMPL_MASK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dir_q <= pdca_pkg::RST_DIR;
    end else if (wr_en & (paddr_i == pdca_pkg::OFF_DIRECTION)) begin
      dir_q <= pwdata_i & pdca_pkg::IMPL_MASK;
    end
  end

  // ----------------------------------------
  // Pin driver
  // ----------------------------------------
  assign pins.latch = latch_q;
  assign pins.func_sel = func_q;
  assign pins.direction = dir_q;
  assign pin_out_o = pins.pin_out;
  assign pin_oe_o = pins.pin_oe;

  pdca_pin_drv u_drv (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pins(pins.drv)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic clr_wr;
  logic lat_rd;
  logic clr_rd;
  assign clr_wr = wr_en & (paddr_i == pdca_pkg::OFF_CLEAR_MASK);
  assign lat_rd = psel_i & penable_i & ~pwrite_i & (paddr_i == pdca_pkg::OFF_OUT_LATCH);
  assign clr_rd = psel_i & penable_i & ~pwrite_i & (paddr_i == pdca_pkg::OFF_CLEAR_MASK);

  sequence clr_then_next;
    clr_wr ##1 1'b1;
  endsequence

  clear_read_zero_a: assert property ( // R01
    @(posedge core_clk_i) disable iff (sys_rst_i) clr_rd |-> (prdata_o == 32'h00000000))
    else $error("Clear alias read returned nonzero data.");

  clear_ones_a: assert property ( // R02
    @(posedge core_clk_i) disable iff (sys_rst_i)
    clr_then_next |-> ((latch_q & $past(pwdata_i) & pdca_pkg::IMPL_MASK) == 32'h00000000))
    else $error("Masked latch bit not cleared.");

  pin_drive_low_a: assert property ( // R03
    @(posedge core_clk_i) disable iff (sys_rst_i)
    clr_wr |=> ##1 ((pin_out_o & $past(pwdata_i, 2) & pin_oe_o) == 32'h00000000))
    else $error("Cleared output pin not driven low.");

  other_pins_keep_a: assert property ( // R04
    @(posedge core_clk_i) disable iff (sys_rst_i)
    clr_wr |=> ((latch_q & ~$past(pwdata_i)) == ($past(latch_q) & ~$past(pwdata_i))))
    else $error("Unselected latch bit changed on clear.");

  ctrl_pins_clear_a: assert property ( // R05
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (clr_wr && pwdata_i[31:25] != 7'h00) |=> ((latch_q[31:25] & $past(pwdata_i[31:25])) == 7'h00))
    else $error("Control pin latch bit not cleared.");

  data_pins_clear_a: assert property ( // R06
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (clr_wr && pwdata_i[15:0] != 16'h0000) |=>
    ((latch_q[15:0] & $past(pwdata_i[15:0])) == 16'h0000))
    else $error("Data pin latch bit not cleared.");

  reserved_zero_a: assert property ( // R07
    @(posedge core_clk_i) disable iff (sys_rst_i) lat_rd |-> (prdata_o[24:16] == 9'h000))
    else $error("Reserved latch bits read nonzero.");

  same_cycle_a: assert property ( // R09
    @(posedge core_clk_i) disable iff (sys_rst_i)
    clr_wr |=> (latch_q == clear_bits($past(latch_q), $past(pwdata_i))))
    else $error("Clear not applied at the accepting edge.");

  latch_read_a: assert property ( // R09
    @(posedge core_clk_i) disable iff (sys_rst_i)
    lat_rd |-> (prdata_o == ($past(latch_q) & pdca_pkg::IMPL_MASK)))
    else $error("Latch read did not return the latch value of the setup cycle.");

  alias_no_store_a: assert property ( // R01
    @(posedge core_clk_i) disable iff (sys_rst_i)
    clr_wr |=> ((func_q == $past(func_q)) && (dir_q == $past(dir_q))))
    else $error("Clear alias write changed another register.");

  pin_enable_gate_a: assert property ( // R03
    @(posedge core_clk_i) disable iff (sys_rst_i)
    1'b1 |=> (pin_oe_o == ($past(func_q & dir_q) & pdca_pkg::IMPL_MASK)))
    else $error("Pin enable does not follow function select and direction.");

  pin_level_gate_a: assert property ( // R03
    @(posedge core_clk_i) disable iff (sys_rst_i)
    1'b1 |=> (pin_out_o == ($past(latch_q & func_q & dir_q) & pdca_pkg::IMPL_MASK)))
    else $error("Pin level does not follow the latch.");

  reserved_pins_off_a: assert property ( // R07
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (pin_oe_o[pdca_pkg::RSVD_HI_BIT:pdca_pkg::RSVD_LO_BIT] == 9'h000))
    else $error("Reserved pin position enabled.");

endmodule : pdca_top

// [bench/testbench.sv]
// Self-checking testbench for the pin output clear alias block over APB.
`timescale 1ns/10ps
module testbench;
  logic core_clk_i;
  logic sys_rst_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [31:0] pin_out_o;
  logic [31:0] pin_oe_o;
  logic [31:0] rd;
  logic err;
  int n_fail;
  int cmp_count;
  localparam logic [31:0] IM = pdca_pkg::IMPL_MASK;

  pdca_top i_pdca_top (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o)
  );

  // ----------------------------------------
  // Clock, tasks and verdict
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask : rdchk

  task automatic pins(input logic [31:0] o, input logic [31:0] e);
    repeat (2) @(posedge core_clk_i);
    check(pin_out_o, o);
    check(pin_oe_o, e);
  endtask : pins

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    #(20 * 20000);
    n_fail++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    n_fail = 0;
    cmp_count = 0;
    sys_rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h00000000;
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    pins(32'h00000000, 32'h00000000);
    rdchk(pdca_pkg::OFF_OUT_LATCH, 32'h00000000);
    rdchk(pdca_pkg::OFF_CLEAR_MASK, 32'h00000000);
    $display("test reset done");
    xfer(1'b1, pdca_pkg::OFF_FUNC_SEL, 32'hffffffff);
    xfer(1'b1, pdca_pkg::OFF_DIRECTION, 32'hffffffff);
    for (int i = 0; i < 32; i++) begin
      if (IM[i]) begin
        xfer(1'b1, pdca_pkg::OFF_OUT_LATCH, 32'hffffffff);
        xfer(1'b1, pdca_pkg::OFF_CLEAR_MASK, 32'h00000001 << i);
        check({31'h0, err}, 32'h00000000);
        rdchk(pdca_pkg::OFF_OUT_LATCH, IM & ~(32'h00000001 << i));
        check(pin_out_o, IM & ~(32'h00000001 << i));
      end
    end
    rdchk(pdca_pkg::OFF_CLEAR_MASK, 32'h00000000);
    $display("test single bit clear done");
    xfer(1'b1, pdca_pkg::OFF_OUT_LATCH, 32'hffffffff);
    xfer(1'b1, pdca_pkg::OFF_FUNC_SEL, 32'hf000ff00);
    xfer(1'b1, pdca_pkg::OFF_DIRECTION, 32'hff00f0f0);
    pins(32'hf000f000, 32'hf000f000);
    xfer(1'b1, pdca_pkg::OFF_CLEAR_MASK, 32'h30003003);
    pins(32'hc000c000, 32'hf000f000);
    rdchk(pdca_pkg::OFF_OUT_LATCH, 32'hce00cffc);
    $display("test function and direction gating done");
    xfer(1'b1, 8'h24, 32'hffffffff);
    check({31'h0, err}, 32'h00000001);
    rdchk(8'h30, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
    rdchk(pdca_pkg::OFF_OUT_LATCH, 32'hce00cffc);
    $display("test unmapped access done");
    summarize();
  end
endmodule : testbench
